//--- rtl/trig_defs.vh
// Purpose: constants for the sample level trigger detector
// Assumes: included by bare name from rtl files
// Notes:   byte offsets on the ahb-lite register window
`ifndef TRIG_DEFS_VH
`define TRIG_DEFS_VH

`define SMP_W          16
`define ALU_W          18
`define CH_COUNT       2
`define ADDR_W         8

`define OFS_GCTRL      8'h00
`define OFS_CMD        8'h04
`define OFS_STATUS     8'h08
`define OFS_CH_BASE    8'h10
`define CH_STRIDE_LSB  4
`define OFS_CH_CTRL    2'h0
`define OFS_CH_PLEVEL  2'h1
`define OFS_CH_SLEVEL  2'h2
`define OFS_CH_HYST    2'h3

`define GCTRL_EXT_EN   0
`define GCTRL_EXT_FALL 1
`define CMD_MANUAL     0
`define CMD_REC_START  1
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_DIR_NEG   2
`define CTRL_SLOPE     3

`define MODE_OFF       2'h0
`define MODE_SINGLE    2'h1
`define MODE_DUAL      2'h2

`define SRC_MANUAL     0
`define SRC_EXT        1
`define SRC_CHAN       2

`define GCTRL_W        2
`define CTRL_W         4
`define SRC_W          3
`define BLK_W          4
`define CH_BLK_FIRST   4'h1
`define WORD_LSB       2
`define WORD_MSB       3
`define ST_PARM_LSB    8
`define ST_SARM_LSB    16
`define ALU_EXT        2
`define ZERO_GCTRL     2'h0
`define ZERO_SRC       3'h0

`define HTRANS_NONSEQ  2'h2
`define ZERO32         32'h0000_0000
`define ZERO_SMP       16'h0000
`define ZERO_CTRL      4'h0

`endif

//--- rtl/level_crossing.v
// Purpose: one single-level crossing detector with hysteresis
// Assumes: value is the alu result, level and hyst are signed/unsigned words
// Notes:   hit is a one-cycle pulse on the sample that lies past the level
`timescale 1ns/100ps
`default_nettype none
`include "trig_defs.vh"

module level_crossing (
    input  wire                     hclk,
    input  wire                     hresetn,
    input  wire                     clear,
    input  wire                     valid,
    input  wire                     dir_neg,
    input  wire signed [`ALU_W-1:0] value,
    input  wire signed [`SMP_W-1:0] level,
    input  wire        [`SMP_W-1:0] hyst,
    output reg                      hit_ff,
    output reg                      armed_ff
);
    wire signed [`ALU_W:0] val_x;
    wire signed [`ALU_W:0] lvl_x;
    wire signed [`ALU_W:0] hys_x;
    wire signed [`ALU_W:0] arm_lvl;
    wire                   past_level;
    wire                   arm_zone;
    reg                    nxt_armed;
    reg                    nxt_hit;

    assign val_x = {value[`ALU_W-1], value};
    assign lvl_x = {{(`ALU_W+1-`SMP_W){level[`SMP_W-1]}}, level};
    assign hys_x = {{(`ALU_W+1-`SMP_W){1'b0}}, hyst};
    // arming level sits below for rising, above for falling
    assign arm_lvl = dir_neg ? lvl_x + hys_x : lvl_x - hys_x;
    // strict compares: a sample equal to the level neither arms nor fires
    assign past_level = dir_neg ? (val_x < lvl_x) : (val_x > lvl_x);
    assign arm_zone   = dir_neg ? (val_x > arm_lvl) : (val_x < arm_lvl);

    always @* begin
        nxt_armed = armed_ff;
        nxt_hit   = 1'b0;
        if (clear) begin
            nxt_armed = 1'b0;
        end else if (valid) begin
            if (armed_ff && past_level) begin
                nxt_hit   = 1'b1;
                nxt_armed = 1'b0;
            end else if (arm_zone) begin
                nxt_armed = 1'b1;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_ff <= 1'b0;
            hit_ff   <= 1'b0;
        end else begin
            armed_ff <= nxt_armed;
            hit_ff   <= nxt_hit;
        end
    end
endmodule
`default_nettype wire

//--- rtl/trigger_detector.v
// Purpose: per-channel digital level triggers combined into a recorder trigger
// Assumes: samples synchronous to hclk, ahb-lite zero-wait register slave
// Notes:   channel logic repeats through a generate loop
`timescale 1ns/100ps
`default_nettype none
`include "trig_defs.vh"

module trigger_detector (
    input  wire                            hclk,
    input  wire                            hresetn,
    input  wire                            hsel,
    input  wire [31:0]                     haddr,
    input  wire [1:0]                      htrans,
    input  wire                            hwrite,
    input  wire [2:0]                      hsize,
    input  wire [31:0]                     hwdata,
    input  wire                            hready,
    output wire                            hreadyout,
    output wire                            hresp,
    output reg  [31:0]                     hrdata_ff,
    input  wire [`CH_COUNT*`SMP_W-1:0]     sample_data,
    input  wire [`CH_COUNT-1:0]            sample_valid,
    input  wire                            ext_trig_in,
    input  wire                            rec_start,
    output reg                             rec_trig_ff,
    output reg  [`CH_COUNT-1:0]            chan_trig_ff
);
    // bus data-phase state
    reg                    wr_pend_ff;
    reg  [`ADDR_W-1:0]     wr_addr_ff;
    wire                   addr_phase;
    wire [`ADDR_W-1:0]     a_addr;
    wire                   wr_now;

    // global registers
    reg  [1:0]             gctrl_ff;
    reg  [2:0]             src_ff;
    reg                    manual_ff;
    reg                    start_ff;
    reg                    ext_prev_ff;

    // per-channel registers, flattened
    reg  [3:0]             ch_ctrl_ff  [0:`CH_COUNT-1];
    reg  [`SMP_W-1:0]      ch_plvl_ff  [0:`CH_COUNT-1];
    reg  [`SMP_W-1:0]      ch_slvl_ff  [0:`CH_COUNT-1];
    reg  [`SMP_W-1:0]      ch_hyst_ff  [0:`CH_COUNT-1];

    wire [`CH_COUNT-1:0]   chan_hit;
    wire [`CH_COUNT-1:0]   p_armed;
    wire [`CH_COUNT-1:0]   s_armed;
    wire                   clear_all;
    wire                   ext_edge;
    wire                   any_chan;
    reg  [31:0]            nxt_rdata;
    wire [`SRC_W-1:0]      trig_src;

    // channel block decode: block 0 of the map holds the global registers
    wire [`BLK_W-1:0]      wr_blk;
    wire [`BLK_W-1:0]      rd_blk;
    wire [1:0]             wr_word;
    wire [1:0]             rd_word;

    integer                ci;
    integer                ri;

    // no wait states: every access ends after one data phase
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
    assign a_addr     = haddr[`ADDR_W-1:0];
    assign wr_now     = wr_pend_ff;
    assign wr_blk     = wr_addr_ff[`ADDR_W-1:`CH_STRIDE_LSB] - `CH_BLK_FIRST;
    assign rd_blk     = a_addr[`ADDR_W-1:`CH_STRIDE_LSB] - `CH_BLK_FIRST;
    assign wr_word    = wr_addr_ff[`WORD_MSB:`WORD_LSB];
    assign rd_word    = a_addr[`WORD_MSB:`WORD_LSB];

    // writes land in the data phase, after hwdata is valid
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= {`ADDR_W{1'b0}};
        end else begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_addr_ff <= addr_phase ? a_addr : wr_addr_ff;
        end
    end

    // command bits are one-cycle strobes, never stored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gctrl_ff  <= `ZERO_GCTRL;
            manual_ff <= 1'b0;
            start_ff  <= 1'b0;
        end else begin
            manual_ff <= 1'b0;
            start_ff  <= 1'b0;
            if (wr_now && wr_addr_ff == `OFS_GCTRL) begin
                gctrl_ff <= hwdata[`GCTRL_W-1:0];
            end
            if (wr_now && wr_addr_ff == `OFS_CMD) begin
                manual_ff <= hwdata[`CMD_MANUAL];
                start_ff  <= hwdata[`CMD_REC_START];
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (ci = 0; ci < `CH_COUNT; ci = ci + 1) begin
                ch_ctrl_ff[ci] <= `ZERO_CTRL;
                ch_plvl_ff[ci] <= `ZERO_SMP;
                ch_slvl_ff[ci] <= `ZERO_SMP;
                ch_hyst_ff[ci] <= `ZERO_SMP;
            end
        end else if (wr_now && wr_addr_ff >= `OFS_CH_BASE) begin
            for (ci = 0; ci < `CH_COUNT; ci = ci + 1) begin
                // one block per channel, four words each
                if (wr_blk == ci[`BLK_W-1:0]) begin
                    case (wr_word)
                        `OFS_CH_CTRL:   ch_ctrl_ff[ci] <= hwdata[`CTRL_W-1:0];
                        `OFS_CH_PLEVEL: ch_plvl_ff[ci] <= hwdata[`SMP_W-1:0];
                        `OFS_CH_SLEVEL: ch_slvl_ff[ci] <= hwdata[`SMP_W-1:0];
                        `OFS_CH_HYST:   ch_hyst_ff[ci] <= hwdata[`SMP_W-1:0];
                        default:        ch_ctrl_ff[ci] <= ch_ctrl_ff[ci];
                    endcase
                end
            end
        end
    end

    // read data registered in the address phase, valid in the data phase;
    // a read right behind a write to the same word still sees the old value
    always @* begin
        nxt_rdata = `ZERO32;
        if (a_addr == `OFS_GCTRL) begin
            nxt_rdata[`GCTRL_W-1:0] = gctrl_ff;
        end else if (a_addr == `OFS_STATUS) begin
            nxt_rdata[`SRC_W-1:0]                = src_ff;
            nxt_rdata[`ST_PARM_LSB +: `CH_COUNT] = p_armed;
            nxt_rdata[`ST_SARM_LSB +: `CH_COUNT] = s_armed;
        end else if (a_addr >= `OFS_CH_BASE) begin
            // blocks past the last channel read zero
            for (ri = 0; ri < `CH_COUNT; ri = ri + 1) begin
                if (rd_blk == ri[`BLK_W-1:0]) begin
                    case (rd_word)
                        `OFS_CH_CTRL:   nxt_rdata[`CTRL_W-1:0] = ch_ctrl_ff[ri];
                        `OFS_CH_PLEVEL: nxt_rdata[`SMP_W-1:0] = ch_plvl_ff[ri];
                        `OFS_CH_SLEVEL: nxt_rdata[`SMP_W-1:0] = ch_slvl_ff[ri];
                        `OFS_CH_HYST:   nxt_rdata[`SMP_W-1:0] = ch_hyst_ff[ri];
                        default:        nxt_rdata = `ZERO32;
                    endcase
                end
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= `ZERO32;
        end else if (addr_phase && !hwrite) begin
            hrdata_ff <= nxt_rdata;
        end
    end

    // recording start from the pin or the command register
    assign clear_all = rec_start | start_ff;

    // external input is taken as synchronous; only its selected edge counts
    // limitation: a pulse on ext_trig_in shorter than one clock may be missed
    assign ext_edge = gctrl_ff[`GCTRL_EXT_EN] &
                      (gctrl_ff[`GCTRL_EXT_FALL] ? (ext_prev_ff & ~ext_trig_in)
                                                 : (~ext_prev_ff & ext_trig_in));

    genvar g;
    generate
        for (g = 0; g < `CH_COUNT; g = g + 1) begin : chan
            wire signed [`SMP_W-1:0] smp;
            reg  signed [`SMP_W-1:0] prev_ff;
            reg                      primed_ff;
            wire signed [`ALU_W-1:0] alu;
            wire signed [`ALU_W-1:0] smp_x;
            wire signed [`ALU_W-1:0] prev_x;
            wire                     slope;
            wire [1:0]               mode;
            wire                     run;
            wire                     dual;
            wire                     dvalid;
            wire                     p_hit;
            wire                     s_hit;

            assign smp   = sample_data[g*`SMP_W +: `SMP_W];
            assign slope = ch_ctrl_ff[g][`CTRL_SLOPE];
            assign mode  = ch_ctrl_ff[g][`CTRL_MODE_HI:`CTRL_MODE_LO];
            // mode 3 is reserved and runs as off
            assign run   = (mode == `MODE_SINGLE) | (mode == `MODE_DUAL);
            assign dual  = (mode == `MODE_DUAL);

            // slope mode needs one older sample before it means anything
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    prev_ff   <= `ZERO_SMP;
                    primed_ff <= 1'b0;
                end else if (clear_all) begin
                    prev_ff   <= `ZERO_SMP;
                    primed_ff <= 1'b0;
                end else if (sample_valid[g]) begin
                    prev_ff   <= smp;
                    primed_ff <= 1'b1;
                end
            end

            // two extra bits: the difference of two full-scale samples never wraps
            assign smp_x  = {{`ALU_EXT{smp[`SMP_W-1]}}, smp};
            assign prev_x = {{`ALU_EXT{prev_ff[`SMP_W-1]}}, prev_ff};
            assign alu    = slope ? smp_x - prev_x : smp_x;
            assign dvalid = sample_valid[g] & run & (primed_ff | ~slope);

            level_crossing u_primary (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .clear    (clear_all | ~run),
                .valid    (dvalid),
                .dir_neg  (ch_ctrl_ff[g][`CTRL_DIR_NEG]),
                .value    (alu),
                .level    (ch_plvl_ff[g]),
                .hyst     (ch_hyst_ff[g]),
                .hit_ff   (p_hit),
                .armed_ff (p_armed[g])
            );

            level_crossing u_secondary (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .clear    (clear_all | ~dual),
                .valid    (dvalid & dual),
                .dir_neg  (~ch_ctrl_ff[g][`CTRL_DIR_NEG]),
                .value    (alu),
                .level    (ch_slvl_ff[g]),
                .hyst     (ch_hyst_ff[g]),
                .hit_ff   (s_hit),
                .armed_ff (s_armed[g])
            );

            // the secondary only counts in dual mode
            assign chan_hit[g] = p_hit | (dual & s_hit);
        end
    endgenerate

    assign any_chan = |chan_hit;

    // trigger sources of this cycle, one bit each
    assign trig_src[`SRC_MANUAL] = manual_ff;
    assign trig_src[`SRC_EXT]    = ext_edge;
    assign trig_src[`SRC_CHAN]   = any_chan;

    // previous external level; resets to the pin's idle low, so no false edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= ext_trig_in;
        end
    end

    // trigger outputs are one-cycle pulses, one clock after the detector hit or other trigger source
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rec_trig_ff  <= 1'b0;
            chan_trig_ff <= {`CH_COUNT{1'b0}};
        end else begin
            chan_trig_ff <= chan_hit;
            rec_trig_ff  <= |trig_src;
        end
    end

    // last trigger source; a trigger in the cycle of a start is kept, not lost
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_ff <= `ZERO_SRC;
        end else if (|trig_src) begin
            src_ff <= trig_src;
        end else if (clear_all) begin
            src_ff <= `ZERO_SRC;
        end
    end
endmodule
`default_nettype wire

//--- bench/trigger_detector_props.sv
// Purpose: port-level checks for trigger_detector
// Assumes: one clock domain, zero-wait bus slave
// Notes:   bound to the design after the module
`timescale 1ns/100ps
`default_nettype none
module trigger_detector_props (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata_ff,
    input wire logic [1:0]  sample_valid,
    input wire logic        rec_start,
    input wire logic        rec_trig_ff,
    input wire logic [1:0]  chan_trig_ff
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // only a read address phase may move read data
    wire logic rd_req = hsel && hready && htrans == 2'h2 && !hwrite;
    sequence smp0_two_ago;
        $past(sample_valid[0], 2);
    endsequence
    sequence smp1_two_ago;
        $past(sample_valid[1], 2);
    endsequence
    sequence start_then_one;
        rec_start ##1 1'b1;
    endsequence
    AST_OR_COMBINE: assert property (chan_trig_ff != 2'h0 |-> rec_trig_ff)
        else $error("channel trigger without recorder trigger");
    AST_CH0_LATENCY: assert property (chan_trig_ff[0] |-> smp0_two_ago)
        else $error("channel 0 trigger not two edges after a sample");
    AST_CH1_LATENCY: assert property (chan_trig_ff[1] |-> smp1_two_ago)
        else $error("channel 1 trigger not two edges after a sample");
    AST_CH0_REARM: assert property (chan_trig_ff[0] |=> !chan_trig_ff[0])
        else $error("channel 0 fired again without rearming");
    AST_CH1_REARM: assert property (chan_trig_ff[1] |=> !chan_trig_ff[1])
        else $error("channel 1 fired again without rearming");
    AST_START_QUIET: assert property (start_then_one |=> chan_trig_ff == 2'h0)
        else $error("channel trigger too soon after recording start");
    AST_NO_WAIT: assert property (hreadyout)
        else $error("slave inserted a wait state");
    AST_OKAY: assert property (!hresp)
        else $error("slave answered with an error");
    AST_RDATA_HOLD: assert property (!rd_req |=> $stable(hrdata_ff))
        else $error("read data moved without a read");
endmodule
bind trigger_detector trigger_detector_props chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata_ff(hrdata_ff), .sample_valid(sample_valid), .rec_start(rec_start),
    .rec_trig_ff(rec_trig_ff), .chan_trig_ff(chan_trig_ff));
`default_nettype wire

//--- bench/adc_stream.sv
// Purpose: sample stream of one converter channel
// Assumes: one strobe cycle per sample
// Notes:   idle data shows the inverse of the last sample
`timescale 1ns/100ps
`default_nettype none
module adc_stream (
    input  wire logic        hclk,
    output var  logic [15:0] data,
    output var  logic        valid
);
    initial begin
        data = 16'h0000;
        valid = 1'b0;
    end
    task automatic push(input logic [15:0] v);
        @(posedge hclk);
        data <= v;
        valid <= 1'b1;
        @(posedge hclk);
        valid <= 1'b0;
        // stale data must not pass for a held sample
        data <= ~v;
    endtask
endmodule
`default_nettype wire

//--- bench/trigger_detector_test.sv
// Purpose: self-checking bench for trigger_detector
// Assumes: zero-wait bus slave, two converter models
// Notes:   each channel scenario restarts recording itself through cfg
`timescale 1ns/100ps
`default_nettype none
module trigger_detector_test;
    logic        hclk = 1'b0;
    logic        hresetn, hsel, hwrite, ext_trig_in, rec_start;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    wire         hreadyout, hresp, rec_trig_ff;
    wire  [31:0] hrdata_ff, sample_data;
    wire  [1:0]  chan_trig_ff, sample_valid;
    int          err_count = 0;
    int          samples_checked = 0;
    always #12.5 hclk = ~hclk;
    trigger_detector DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata_ff(hrdata_ff), .sample_data(sample_data), .sample_valid(sample_valid),
        .ext_trig_in(ext_trig_in), .rec_start(rec_start), .rec_trig_ff(rec_trig_ff),
        .chan_trig_ff(chan_trig_ff));
    adc_stream src0 (.hclk(hclk), .data(sample_data[15:0]), .valid(sample_valid[0]));
    adc_stream src1 (.hclk(hclk), .data(sample_data[31:16]), .valid(sample_valid[1]));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata_ff;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        bus(1'b0, a, 32'h0000_0000);
        check(n, rd, e);
    endtask
    task stat_chk(input logic [2:0] e);
        bus(1'b0, 8'h08, 32'h0000_0000);
        check("status source", rd & 32'h0000_0007, {29'h0, e});
    endtask
    task cfg(input logic ch, input logic [3:0] c, input logic [15:0] p, input logic [15:0] s,
             input logic [15:0] h);
        bus(1'b1, {3'h0, ch, 4'h0} + 8'h10, {28'h0, c});
        bus(1'b1, {3'h0, ch, 4'h4} + 8'h10, {16'h0, p});
        bus(1'b1, {3'h0, ch, 4'h8} + 8'h10, {16'h0, s});
        bus(1'b1, {3'h0, ch, 4'hC} + 8'h10, {16'h0, h});
        @(posedge hclk);
        rec_start <= 1'b1;
        @(posedge hclk);
        rec_start <= 1'b0;
    endtask
    task send(input logic ch, input logic [15:0] v, input logic e);
        if (ch)
            src1.push(v);
        else
            src0.push(v);
        @(posedge hclk);
        #1;
        check("chan_trig", 32'(chan_trig_ff[ch]), 32'(e));
        check("rec_trig", 32'(rec_trig_ff), 32'(e));
    endtask
    task wait_rec(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if (rec_trig_ff === 1'b1)
                seen = 1'b1;
        end
        check("rec_trig pulse", 32'(seen), 32'h0000_0001);
    endtask
    task t_regs;
        rchk(8'h00, 32'h0000_0000, "gctrl reset");
        rchk(8'h10, 32'h0000_0000, "ctrl0 reset");
        rchk(8'h2C, 32'h0000_0000, "hyst1 reset");
        bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
        rchk(8'hFC, 32'h0000_0000, "unmapped");
        bus(1'b1, 8'h14, 32'hFFFF_1234);
        rchk(8'h14, 32'h0000_1234, "plevel0 width");
        rchk(8'h04, 32'h0000_0000, "cmd reads zero");
    endtask
    task t_pos;
        cfg(1'b0, 4'h1, 16'h0064, 16'h0000, 16'h000A);
        send(1'b0, 16'h00C8, 1'b0);
        send(1'b0, 16'h005F, 1'b0);
        send(1'b0, 16'h0096, 1'b0);
        send(1'b0, 16'h0059, 1'b0);
        send(1'b0, 16'h0064, 1'b0);
        send(1'b0, 16'h0065, 1'b1);
        send(1'b0, 16'h005F, 1'b0);
        send(1'b0, 16'h0078, 1'b0);
        send(1'b0, 16'h0055, 1'b0);
        send(1'b0, 16'h0082, 1'b1);
        stat_chk(3'h4);
    endtask
    task t_neg;
        cfg(1'b1, 4'h5, 16'hFFCE, 16'h0000, 16'h0000);
        send(1'b1, 16'hFF9C, 1'b0);
        send(1'b1, 16'hFFD8, 1'b0);
        send(1'b1, 16'hFFCE, 1'b0);
        send(1'b1, 16'hFFCD, 1'b1);
    endtask
    task t_dual;
        cfg(1'b0, 4'h2, 16'h0064, 16'hFF9C, 16'h0005);
        send(1'b0, 16'h0000, 1'b0);
        send(1'b0, 16'h0065, 1'b1);
        send(1'b0, 16'hFF9B, 1'b1);
    endtask
    task t_off;
        cfg(1'b0, 4'h0, 16'h0064, 16'h0000, 16'h0000);
        send(1'b0, 16'h0000, 1'b0);
        send(1'b0, 16'h00C8, 1'b0);
        cfg(1'b0, 4'h3, 16'h0064, 16'h0000, 16'h0000);
        send(1'b0, 16'h0000, 1'b0);
        send(1'b0, 16'h00C8, 1'b0);
    endtask
    task t_slope;
        cfg(1'b0, 4'h9, 16'h000A, 16'h0000, 16'h0000);
        send(1'b0, 16'h0000, 1'b0);
        send(1'b0, 16'h0000, 1'b0);
        send(1'b0, 16'h0032, 1'b1);
        send(1'b0, 16'h003C, 1'b0);
    endtask
    task t_src;
        bus(1'b1, 8'h04, 32'h0000_0001);
        wait_rec(4);
        stat_chk(3'h1);
        bus(1'b1, 8'h00, 32'h0000_0001);
        @(posedge hclk);
        ext_trig_in <= 1'b1;
        wait_rec(4);
        stat_chk(3'h2);
        bus(1'b1, 8'h00, 32'h0000_0003);
        @(posedge hclk);
        ext_trig_in <= 1'b0;
        wait_rec(4);
        bus(1'b1, 8'h04, 32'h0000_0002);
        stat_chk(3'h0);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge hclk);
        err_count++;
        end_of_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        htrans = 2'h0;
        hsize = 3'h2;
        ext_trig_in = 1'b0;
        rec_start = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_pos;
        t_neg;
        t_dual;
        t_off;
        t_slope;
        t_src;
        end_of_test;
    end
endmodule
`default_nettype wire
